// >>> host_bus_model.sv
// Host processor bus model driving the slot pins.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import slot_decode_pkg::*;
(
  input wire logic pclk,
  output var host_bus_t host_bus
);
  // The host decodes no other card here, so the chosen block is always free.
  initial host_bus = '{addr: 20'h0, aen: 1'b0, default: 1'b1};
  // Strobes are {ior_n, iow_n, memr_n, memw_n}; dk is {dack1_n, dack3_n}.
  task automatic cyc(input logic [19:0] a, input logic [3:0] st, input logic aen,
                     input logic [1:0] dk);
    host_bus <= '{a, aen, st[3], st[2], st[1], st[0], dk[1], dk[0]};
    @(posedge pclk);
  endtask
  // Released address lines show the inverse so stale values are never mistaken for live.
  task automatic idle();
    host_bus <= '{~host_bus.addr, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// >>> host_slot_resource_decode.sv
// Expansion slot resource decoder with an APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "slot_decode_map.svh"

module host_slot_resource_decode
  import slot_decode_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire host_bus_t   host_bus,
  input  wire logic        card_irq_req,
  input  wire logic        card_dma_req,
  output var  card_sel_t   card_sel,
  output var  logic        card_dack,
  output var  logic [7:0]  irq_out,
  output var  logic [7:0]  irq_oe,
  output var  logic [3:0]  drq_out,
  output var  logic [3:0]  drq_oe
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Switches read as zero when up, so the compare value is the inverse.
  function automatic logic [5:0] addr_bits(input logic [5:0] up);
    addr_bits = ~up;
  endfunction

  function automatic logic [2:0] irq_level(input logic [2:0] up);
    irq_level = ~up;
  endfunction

  // Only reads reach the read-only store; a write below the RAM page is dropped.
  function automatic logic rom_read(input logic hit, input logic ram, input logic rd_n);
    rom_read = hit && !ram && !rd_n;
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  host_bus_t   bus_meta_r;
  host_bus_t   bus_r;
  switch_cfg_t cfg_r;
  logic [1:0]  ctrl_r;
  logic        access_r;
  logic        ack_phase;
  logic        wr_en;
  logic        io_hit;
  logic        mem_hit;
  logic        io_cycle;
  logic        mem_cycle;
  logic        ram_page;
  logic [2:0]  lvl;
  logic        ch3;
  logic        dack_sel;
  logic        dack_live;
  logic        irq_allowed;
  logic        irq_level_ok;
  logic        mapped;
  logic [31:0] rd_mux;
  logic [9:0]  io_base;
  logic [19:0] mem_base;
  logic        io_hit_r;
  logic        rom_hit_r;
  logic        ram_hit_r;
  logic        dack_r;

  // ****************************************************************
  // Host bus synchroniser
  // ****************************************************************
  // The host bus runs on its own timing, so every line passes two flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_meta_r <= '{addr: 20'h00000, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1,
                      memr_n: 1'b1, memw_n: 1'b1, dack1_n: 1'b1, dack3_n: 1'b1};
      bus_r      <= '{addr: 20'h00000, aen: 1'b1, ior_n: 1'b1, iow_n: 1'b1,
                      memr_n: 1'b1, memw_n: 1'b1, dack1_n: 1'b1, dack3_n: 1'b1};
    end else begin
      bus_meta_r <= host_bus;
      bus_r      <= bus_meta_r;
    end
  end

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign lvl       = irq_level(cfg_r.int_up);
  assign ch3       = cfg_r.dma_up;
  assign io_base   = {addr_bits(cfg_r.io_up), 4'h0};
  assign mem_base  = {addr_bits(cfg_r.mem_up), 14'h0000};
  assign io_cycle  = !bus_r.aen && (!bus_r.ior_n || !bus_r.iow_n);
  assign mem_cycle = !bus_r.memr_n || !bus_r.memw_n;
  // No overlap check against other cards is attempted here.
  assign io_hit    = ctrl_r[`SD_CTRL_CARD_EN] && io_cycle &&
                     (bus_r.addr[9:4] == addr_bits(cfg_r.io_up));
  assign mem_hit   = ctrl_r[`SD_CTRL_CARD_EN] && mem_cycle &&
                     (bus_r.addr[19:14] == addr_bits(cfg_r.mem_up));
  assign ram_page  = (bus_r.addr[13:12] == `SD_RAM_PAGE);

  // Writes into the read-only store are simply not selected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      card_sel <= '{io_sel: 1'b0, rom_sel: 1'b0, ram_sel: 1'b0, wr: 1'b0,
                    offset: 14'h0000};
    end else begin
      card_sel.io_sel  <= io_hit;
      card_sel.rom_sel <= rom_read(mem_hit, ram_page, bus_r.memr_n);
      card_sel.ram_sel <= mem_hit && ram_page;
      card_sel.wr      <= io_hit ? !bus_r.iow_n : !bus_r.memw_n;
      card_sel.offset  <= io_hit ? {10'h000, bus_r.addr[3:0]} : bus_r.addr[13:0];
    end
  end

  // ****************************************************************
  // Interrupt request line
  // ****************************************************************
  assign irq_level_ok = (lvl >= `SD_MIN_IRQ_LVL);
  assign irq_allowed  = ctrl_r[`SD_CTRL_DMA_EN] && irq_level_ok;

  // Only the selected level is ever enabled; a level below two is left alone
  // so a misset switch cannot fight the timer or keyboard line.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out <= 8'h00;
      irq_oe  <= 8'h00;
    end else begin
      irq_out <= 8'h00;
      irq_oe  <= 8'h00;
      if (irq_allowed) begin
        irq_oe[lvl]  <= 1'b1;
        irq_out[lvl] <= card_irq_req;
      end
    end
  end

  // ****************************************************************
  // DMA channel routing
  // ****************************************************************
  assign dack_sel = ch3 ? !bus_r.dack3_n : !bus_r.dack1_n;
  // An acknowledge on the routed channel counts only while DMA is enabled.
  assign dack_live = dack_sel && ctrl_r[`SD_CTRL_DMA_EN];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drq_out   <= 4'h0;
      drq_oe    <= 4'h0;
      card_dack <= 1'b0;
    end else begin
      drq_out   <= 4'h0;
      drq_oe    <= 4'h0;
      card_dack <= dack_live;
      if (ctrl_r[`SD_CTRL_DMA_EN]) begin
        if (ch3) begin
          drq_oe[3]  <= 1'b1;
          drq_out[3] <= card_dma_req;
        end else begin
          drq_oe[1]  <= 1'b1;
          drq_out[1] <= card_dma_req;
        end
      end
    end
  end

  // ****************************************************************
  // Sticky activity flags for software
  // ****************************************************************
  // A new hit in the cycle of a status write still sets its flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_hit_r  <= 1'b0;
      rom_hit_r <= 1'b0;
      ram_hit_r <= 1'b0;
      dack_r    <= 1'b0;
    end else begin
      if (wr_en && paddr == `SD_OFF_STATUS) begin
        if (pwdata[`SD_ST_IO_HIT])  io_hit_r  <= 1'b0;
        if (pwdata[`SD_ST_ROM_HIT]) rom_hit_r <= 1'b0;
        if (pwdata[`SD_ST_RAM_HIT]) ram_hit_r <= 1'b0;
        if (pwdata[`SD_ST_DACK])    dack_r    <= 1'b0;
      end
      if (io_hit) io_hit_r <= 1'b1;
      if (rom_read(mem_hit, ram_page, bus_r.memr_n)) rom_hit_r <= 1'b1;
      if (mem_hit && ram_page) ram_hit_r <= 1'b1;
      if (dack_live) dack_r <= 1'b1;
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // One wait state keeps every bus output straight from a flop.
  assign ack_phase = psel && penable && !access_r;
  assign wr_en     = psel && penable && access_r && pwrite;
  assign mapped    = (paddr == `SD_OFF_CFG) || (paddr == `SD_OFF_CTRL) ||
                     (paddr == `SD_OFF_STATUS) || (paddr == `SD_OFF_IOBASE) ||
                     (paddr == `SD_OFF_MEMBASE);

  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      `SD_OFF_CFG: begin
        rd_mux[`SD_CFG_IO_MSB:`SD_CFG_IO_LSB]   = cfg_r.io_up;
        rd_mux[`SD_CFG_MEM_MSB:`SD_CFG_MEM_LSB] = cfg_r.mem_up;
        rd_mux[`SD_CFG_INT_MSB:`SD_CFG_INT_LSB] = cfg_r.int_up;
        rd_mux[`SD_CFG_DMA_BIT]                 = cfg_r.dma_up;
      end
      `SD_OFF_CTRL: begin
        rd_mux[1:0] = ctrl_r;
      end
      `SD_OFF_STATUS: begin
        rd_mux[`SD_ST_IO_HIT]               = io_hit_r;
        rd_mux[`SD_ST_ROM_HIT]              = rom_hit_r;
        rd_mux[`SD_ST_RAM_HIT]              = ram_hit_r;
        rd_mux[`SD_ST_DACK]                 = dack_r;
        rd_mux[`SD_ST_LVL_MSB:`SD_ST_LVL_LSB] = lvl;
        rd_mux[`SD_ST_CH3]                  = ch3;
        rd_mux[`SD_ST_IRQ_ON]               = irq_allowed;
        rd_mux[`SD_ST_DRQ_ON]               = ctrl_r[`SD_CTRL_DMA_EN];
      end
      `SD_OFF_IOBASE: begin
        rd_mux[9:0] = io_base;
      end
      `SD_OFF_MEMBASE: begin
        rd_mux[19:0] = mem_base;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_r <= 1'b0;
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h00000000;
    end else begin
      access_r <= ack_phase;
      pready   <= ack_phase;
      pslverr  <= ack_phase && !mapped;
      if (ack_phase && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ****************************************************************
  // Configuration and control registers
  // ****************************************************************
  // Reset brings back the shipped switch positions.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= '{io_up: `SD_RST_IO_UP, mem_up: `SD_RST_MEM_UP,
                 int_up: `SD_RST_INT_UP, dma_up: `SD_RST_DMA_UP};
    end else if (wr_en && paddr == `SD_OFF_CFG) begin
      cfg_r.io_up  <= pwdata[`SD_CFG_IO_MSB:`SD_CFG_IO_LSB];
      cfg_r.mem_up <= pwdata[`SD_CFG_MEM_MSB:`SD_CFG_MEM_LSB];
      cfg_r.int_up <= pwdata[`SD_CFG_INT_MSB:`SD_CFG_INT_LSB];
      cfg_r.dma_up <= pwdata[`SD_CFG_DMA_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `SD_RST_CTRL;
    end else if (wr_en && paddr == `SD_OFF_CTRL) begin
      ctrl_r <= pwdata[1:0];
    end
  end

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // The register fields must match the six, six and three switch banks.
  if ((`SD_CFG_IO_MSB - `SD_CFG_IO_LSB != 5) || (`SD_CFG_MEM_MSB - `SD_CFG_MEM_LSB != 5) ||
      (`SD_CFG_INT_MSB - `SD_CFG_INT_LSB != 2)) begin : g_bad_field
    $error("switch field widths do not match the switch banks");
  end

endmodule
`default_nettype wire

// >>> host_slot_resource_decode_sva.sv
// Port checks for the slot resource decoder.
`timescale 1ns/1ps
`default_nettype none
module host_slot_resource_decode_sva
  import slot_decode_pkg::*;
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       pready,
  input wire host_bus_t  host_bus,
  input wire logic       card_irq_req,
  input wire logic       card_dma_req,
  input wire card_sel_t  card_sel,
  input wire logic [7:0] irq_out,
  input wire logic [7:0] irq_oe,
  input wire logic [3:0] drq_out,
  input wire logic [3:0] drq_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_IO_CAUSE: assert property (card_sel.io_sel |-> !$past(host_bus.aen, 3) &&
    $past(host_bus.addr[3:0], 3) == card_sel.offset[3:0]) else $error("bad I/O select");
  AST_ROM_READ: assert property (card_sel.rom_sel |-> !card_sel.wr &&
    !$past(host_bus.memr_n, 3) && card_sel.offset[13:12] != 2'h3) else $error("bad ROM select");
  AST_RAM_TOP: assert property (card_sel.ram_sel |-> card_sel.offset[13:12] == 2'h3)
    else $error("RAM select outside top page");
  AST_ONE_TARGET: assert property ($onehot0({card_sel.io_sel, card_sel.rom_sel,
    card_sel.ram_sel})) else $error("two targets selected");
  AST_IRQ_LEVEL: assert property ($onehot0(irq_oe) && irq_oe[1:0] == 2'h0)
    else $error("bad interrupt enable");
  AST_DRQ_CHAN: assert property (drq_oe == 4'h0 || drq_oe == 4'h2 || drq_oe == 4'h8)
    else $error("bad DMA request enable");
  AST_IRQ_DMA_ONLY: assert property (|irq_oe |-> |drq_oe)
    else $error("interrupt line driven without DMA");
  AST_IRQ_FOLLOW: assert property (|irq_oe && $stable(irq_oe) |->
    (|(irq_out & irq_oe)) == $past(card_irq_req)) else $error("interrupt not following");
  AST_DRQ_FOLLOW: assert property (|drq_oe && $stable(drq_oe) |->
    (|(drq_out & drq_oe)) == $past(card_dma_req)) else $error("DMA request not following");
endmodule
`default_nettype wire

// >>> host_slot_resource_decode_tb.sv
// Self-checking bench for the slot resource decoder.
`timescale 1ns/1ps
`default_nettype none
module host_slot_resource_decode_tb;
  import slot_decode_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        card_irq_req, card_dma_req, card_dack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  irq_out, irq_oe;
  logic [3:0]  drq_out, drq_oe;
  host_bus_t   host_bus;
  card_sel_t   card_sel;
  int          n_errors, cmp_count, cycles;
  host_slot_resource_decode u_host_slot_resource_decode (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .host_bus, .card_irq_req,
    .card_dma_req, .card_sel, .card_dack, .irq_out, .irq_oe, .drq_out, .drq_oe);
  host_bus_model u_host_bus_model (.pclk, .host_bus);
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0);
  endtask
  // ex is {io, rom, ram, wr}; the offset is only meaningful while a target is selected.
  task automatic hb(input logic [19:0] a, input logic [3:0] st, input logic aen,
                    input logic [3:0] ex);
    logic [2:0] s;
    u_host_bus_model.cyc(a, st, aen, 2'h3);
    repeat (4) @(posedge pclk);
    s = {card_sel.io_sel, card_sel.rom_sel, card_sel.ram_sel};
    chk({s, card_sel.wr & (|s)}, ex);
    if (ex[3]) chk(card_sel.offset[3:0], a[3:0]);
    else if (|ex[2:1]) chk(card_sel.offset, a[13:0]);
    u_host_bus_model.idle();
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_reset();
    rd(12'h000, 32'h0102_0f0f, 1'b0);
    rd(12'h004, 32'h2, 1'b0);
    rd(12'h00c, 32'h300, 1'b0);
    rd(12'h010, 32'hc0000, 1'b0);
    rd(12'h008, 32'h150, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
  endtask
  task automatic t_io();
    hb(20'h00305, 4'h7, 1'b0, 4'h8);
    hb(20'h0030f, 4'hb, 1'b0, 4'h9);
    hb(20'h00315, 4'h7, 1'b0, 4'h0);
    hb(20'h00305, 4'h7, 1'b1, 4'h0);
    wr(12'h004, 32'h0);
    hb(20'h00305, 4'h7, 1'b0, 4'h0);
    wr(12'h004, 32'h2);
    wr(12'h000, 32'h0102_0f1e);
    rd(12'h00c, 32'h210, 1'b0);
    hb(20'h0021a, 4'h7, 1'b0, 4'h8);
    hb(20'h0030a, 4'h7, 1'b0, 4'h0);
  endtask
  task automatic t_mem();
    hb(20'hc2fff, 4'hd, 1'b0, 4'h4);
    hb(20'hc3000, 4'hd, 1'b0, 4'h2);
    hb(20'hc3ffe, 4'he, 1'b0, 4'h3);
    hb(20'hc0010, 4'he, 1'b0, 4'h0);
    hb(20'hd0000, 4'hd, 1'b0, 4'h0);
    hb(20'hbffff, 4'hd, 1'b0, 4'h0);
    wr(12'h000, 32'h0102_060f);
    rd(12'h010, 32'he4000, 1'b0);
    hb(20'he4123, 4'hd, 1'b0, 4'h4);
  endtask
  task automatic t_dma();
    wr(12'h000, 32'h0102_0f0f);
    wr(12'h004, 32'h3);
    card_irq_req <= 1'b1;
    card_dma_req <= 1'b1;
    repeat (2) @(posedge pclk);
    chk(irq_oe, 32'h20);
    chk(drq_oe & drq_out, 32'h8);
    u_host_bus_model.cyc(20'h0, 4'hf, 1'b1, 2'h2);
    repeat (4) @(posedge pclk);
    chk(card_dack, 32'h1);
    u_host_bus_model.idle();
    rd(12'h008, 32'h75f, 1'b0);
    wr(12'h008, 32'hf);
    rd(12'h008, 32'h750, 1'b0);
    wr(12'h000, 32'h0004_0f0f);
    repeat (2) @(posedge pclk);
    chk(irq_oe & irq_out, 32'h8);
    chk(drq_oe, 32'h2);
    u_host_bus_model.cyc(20'h0, 4'hf, 1'b1, 2'h2);
    repeat (4) @(posedge pclk);
    chk(card_dack, 32'h0);
    u_host_bus_model.cyc(20'h0, 4'hf, 1'b1, 2'h1);
    repeat (4) @(posedge pclk);
    chk(card_dack, 32'h1);
    u_host_bus_model.idle();
    wr(12'h000, 32'h0106_0f0f);
    repeat (2) @(posedge pclk);
    chk(irq_oe, 32'h0);
    wr(12'h004, 32'h2);
    repeat (2) @(posedge pclk);
    chk({irq_oe, drq_oe}, 32'h0);
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {card_irq_req, card_dma_req, n_errors, cmp_count, cycles} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_io();
    t_mem();
    t_dma();
    test_done();
  end
endmodule
bind host_slot_resource_decode host_slot_resource_decode_sva u_sva (.pclk, .presetn,
  .pready, .host_bus, .card_irq_req, .card_dma_req, .card_sel, .irq_out, .irq_oe,
  .drq_out, .drq_oe);
`default_nettype wire

// >>> slot_decode_map.svh
// Register offsets, field positions, reset values and decode constants of the slot decoder.
`ifndef SLOT_DECODE_MAP_SVH
`define SLOT_DECODE_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SD_OFF_CFG      12'h000
`define SD_OFF_CTRL     12'h004
`define SD_OFF_STATUS   12'h008
`define SD_OFF_IOBASE   12'h00c
`define SD_OFF_MEMBASE  12'h010

// ****************************************************************
// Configuration register fields (one bit per switch, high = up)
// ****************************************************************
`define SD_CFG_IO_LSB   0
`define SD_CFG_IO_MSB   5
`define SD_CFG_MEM_LSB  8
`define SD_CFG_MEM_MSB  13
`define SD_CFG_INT_LSB  16
`define SD_CFG_INT_MSB  18
`define SD_CFG_DMA_BIT  24

// ****************************************************************
// Factory switch positions: I/O 300h, memory C0000h, level 5, channel 3
// ****************************************************************
`define SD_RST_IO_UP    6'h0f
`define SD_RST_MEM_UP   6'h0f
`define SD_RST_INT_UP   3'h2
`define SD_RST_DMA_UP   1'h1

// ****************************************************************
// Control register fields and reset value
// ****************************************************************
`define SD_CTRL_DMA_EN  0
`define SD_CTRL_CARD_EN 1
`define SD_RST_CTRL     2'h2

// ****************************************************************
// Status register fields
// ****************************************************************
`define SD_ST_IO_HIT    0
`define SD_ST_ROM_HIT   1
`define SD_ST_RAM_HIT   2
`define SD_ST_DACK      3
`define SD_ST_LVL_LSB   4
`define SD_ST_LVL_MSB   6
`define SD_ST_CH3       8
`define SD_ST_IRQ_ON    9
`define SD_ST_DRQ_ON    10

// ****************************************************************
// Memory window split: top 4 Kbyte of the 16 Kbyte window is RAM
// ****************************************************************
`define SD_RAM_PAGE     2'h3
`define SD_MIN_IRQ_LVL  3'h2

`endif

// >>> slot_decode_pkg.sv
// Types shared by the slot resource decoder.
`default_nettype none
package slot_decode_pkg;

  typedef struct packed {
    logic [19:0] addr;
    logic        aen;
    logic        ior_n;
    logic        iow_n;
    logic        memr_n;
    logic        memw_n;
    logic        dack1_n;
    logic        dack3_n;
  } host_bus_t;

  typedef struct packed {
    logic [5:0] io_up;
    logic [5:0] mem_up;
    logic [2:0] int_up;
    logic       dma_up;
  } switch_cfg_t;

  typedef struct packed {
    logic        io_sel;
    logic        rom_sel;
    logic        ram_sel;
    logic        wr;
    logic [13:0] offset;
  } card_sel_t;

endpackage
`default_nettype wire
